// *** hdl/lds_pkg.sv ***
// package for the line-scan readout sequencer: timing counts, pixel counts, pin bundle
// assumes a single 100 MHz system clock; the scan clock arrives as a sampled pin
package lds_pkg;

  // ==========================================================================
  // scan timing, in falling edges of the scan clock
  // ==========================================================================
  localparam logic [4:0] LDS_FIRST_PIX_EDGE = 5'h12; // pixel 0 driven at edge 18, before 19th
  localparam logic [4:0] LDS_INT_START_EDGE = 5'h08; // edges after reset rise
  localparam logic [4:0] LDS_INT_END_EDGE = 5'h07;   // edges after reset fall
  localparam logic [4:0] LDS_EDGE_MAX = 5'h1F;       // counters saturate here
  localparam logic [1:0] LDS_LAST_PHASE = 2'h3;      // four scan clocks per pixel
  localparam logic [1:0] LDS_TRIG_ON_PHASE = 2'h1;   // trigger high after edge 19 ...
  localparam logic [1:0] LDS_TRIG_HOLD_PHASE = 2'h2; // ... and still high across edge 20

  // ==========================================================================
  // pixels per line for a two-inch unit, and buffering
  // ==========================================================================
  localparam int LDS_PIX_FINE = 128;
  localparam int LDS_PIX_COARSE = 64;
  localparam int LDS_FIFO_DEPTH = 32;
  localparam int LDS_PIX_W = 12;
  localparam int LDS_CNT_W = 10;

  // ==========================================================================
  // readout state, one-hot
  // ==========================================================================
  typedef enum logic [3:0] {
    LDS_ST_IDLE = 4'b0001,
    LDS_ST_LEAD = 4'b0010,
    LDS_ST_CHAIN = 4'b0100,
    LDS_ST_READ = 4'b1000
  } lds_state_t;

  // static and pulse pins from the controller, synchronised as one bundle
  typedef struct packed {
    logic scan_clk;
    logic scan_rst_n;
    logic chain_start_in_n;
    logic lead_follower_select;
    logic gain_select;
    logic pitch_select;
  } lds_pins_t;

endpackage : lds_pkg

// *** hdl/lds_readout.sv ***
// line-scan readout sequencer of a linear photodiode detector, plus its pixel FIFO
// assumes all controller pins are asynchronous to i_clk and the scan clock is far slower
`timescale 1ns/10ps

// ============================================================================
// pixel FIFO
// ============================================================================
module lds_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] wr_d;
  logic [AW:0] rd_q;
  logic [AW:0] rd_d;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  always_comb begin
    o_in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    o_out_valid = (wr_q != rd_q);
    o_out_data = mem_q[rd_q[AW-1:0]];
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  // pointers only; storage is written without reset to stay a plain RAM
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end
endmodule : lds_fifo

// ============================================================================
// readout sequencer
// ============================================================================
module lds_readout import lds_pkg::*; #(
  parameter int PIX_W = LDS_PIX_W,
  parameter int FIFO_DEPTH = LDS_FIFO_DEPTH,
  parameter int LEN_MULT = 1,      // 1 for two-inch, 2 for four-inch
  parameter bit COARSE_ONLY = 1'b0 // coarse-pitch-only build ignores pitch select
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scan_clk,
  input wire logic i_scan_rst_n,
  input wire logic i_chain_start_in_n,
  input wire logic i_lead_follower_select,
  input wire logic i_gain_select,
  input wire logic i_pitch_select,
  input wire logic i_pix_valid,
  input wire logic [PIX_W-1:0] i_pix_data,
  output logic o_pix_ready,
  output logic [PIX_W-1:0] o_video,
  output logic o_video_oe_n,
  output logic o_trig,
  output logic o_end_of_scan_out_n,
  output logic o_integrating,
  output logic o_high_gain,
  output logic o_underrun
);

  // pixels in a line for the latched pitch
  function automatic logic [LDS_CNT_W-1:0] lds_npix(input logic fine);
    if (fine && !COARSE_ONLY) begin
      lds_npix = LDS_CNT_W'(LDS_PIX_FINE * LEN_MULT);
    end else begin
      lds_npix = LDS_CNT_W'(LDS_PIX_COARSE * LEN_MULT);
    end
  endfunction : lds_npix

  // ==========================================================================
  // pin synchronisers and scan clock edge detect
  // ==========================================================================
  lds_pins_t pins_raw;
  lds_pins_t s1_q;
  lds_pins_t s2_q;
  logic sclk_prev_q;
  logic fall;

  always_comb begin
    pins_raw = '{scan_clk: i_scan_clk, scan_rst_n: i_scan_rst_n,
                 chain_start_in_n: i_chain_start_in_n,
                 lead_follower_select: i_lead_follower_select,
                 gain_select: i_gain_select, pitch_select: i_pitch_select};
    fall = sclk_prev_q && !s2_q.scan_clk;
  end

  // only the second stage is read by any logic
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= '{default: 1'b1};
      s2_q <= '{default: 1'b1};
      sclk_prev_q <= 1'b1;
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      sclk_prev_q <= s2_q.scan_clk;
    end
  end

  // ==========================================================================
  // pixel FIFO in the video path
  // ==========================================================================
  logic fifo_valid;
  logic [PIX_W-1:0] fifo_data;
  logic pop;

  lds_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(i_pix_valid),
    .i_in_data(i_pix_data),
    .o_in_ready(o_pix_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(pop)
  );

  // ==========================================================================
  // readout sequence
  // ==========================================================================
  lds_state_t st_q, st_d;
  logic [4:0] edge_q, edge_d;
  logic [4:0] rise_q, rise_d;
  logic [1:0] phase_q, phase_d;
  logic [LDS_CNT_W-1:0] pix_q, pix_d;
  logic [LDS_CNT_W-1:0] last_pix;
  logic [PIX_W-1:0] video_q, video_d;
  logic drive_q, drive_d;
  logic integ_q, integ_d;
  logic gain_q, gain_d;
  logic pitch_q, pitch_d;
  logic under_q, under_d;
  logic rstp_q, rstp_d;
  logic trig_q, trig_d;
  logic last_n_q, last_n_d;
  logic present;

  // everything moves only on a sampled scan clock falling edge
  always_comb begin
    st_d = st_q;
    edge_d = edge_q;
    rise_d = rise_q;
    phase_d = phase_q;
    pix_d = pix_q;
    video_d = video_q;
    drive_d = drive_q;
    integ_d = integ_q;
    gain_d = gain_q;
    pitch_d = pitch_q;
    under_d = under_q;
    rstp_d = rstp_q;
    present = 1'b0;
    pop = 1'b0;
    last_pix = lds_npix(pitch_q) - 1'b1;
    if (fall) begin
      rstp_d = s2_q.scan_rst_n;
      gain_d = s2_q.gain_select;
      edge_d = (edge_q == LDS_EDGE_MAX) ? edge_q : edge_q + 5'h01;
      rise_d = (rise_q == LDS_EDGE_MAX) ? rise_q : rise_q + 5'h01;
      if (rstp_q && !s2_q.scan_rst_n) begin
        // reset fall: new line, whatever was in progress is abandoned
        edge_d = '0;
        pix_d = '0;
        phase_d = '0;
        drive_d = 1'b0;
        under_d = 1'b0;
        pitch_d = s2_q.pitch_select;
        st_d = s2_q.lead_follower_select ? LDS_ST_LEAD : LDS_ST_CHAIN;
      end else begin
        if (!rstp_q && s2_q.scan_rst_n) begin
          rise_d = '0;
        end
        unique case (st_q)
          LDS_ST_IDLE: begin
          end
          LDS_ST_LEAD: begin
            present = (edge_d == LDS_FIRST_PIX_EDGE);
          end
          LDS_ST_CHAIN: begin
            present = !s2_q.chain_start_in_n;
          end
          LDS_ST_READ: begin
            phase_d = phase_q + 2'h1;
            if (phase_q == LDS_LAST_PHASE) begin
              if (pix_q == last_pix) begin
                st_d = LDS_ST_IDLE;
                drive_d = 1'b0;
              end else begin
                pix_d = pix_q + 1'b1;
                present = 1'b1;
              end
            end
          end
        endcase
      end
      // integration window trails the reset edges
      if (s2_q.scan_rst_n && rise_d == LDS_INT_START_EDGE) begin
        integ_d = 1'b1;
      end
      if (!s2_q.scan_rst_n && edge_d == LDS_INT_END_EDGE) begin
        integ_d = 1'b0;
      end
      if (present) begin
        st_d = LDS_ST_READ;
        phase_d = '0;
        drive_d = 1'b1;
        pop = fifo_valid;
        // an empty FIFO still keeps the slot; the word shows zero and is flagged
        video_d = fifo_valid ? fifo_data : '0;
        under_d = under_q || !fifo_valid;
      end
    end
    trig_d = (st_d == LDS_ST_READ) &&
             (phase_d == LDS_TRIG_ON_PHASE || phase_d == LDS_TRIG_HOLD_PHASE);
    last_n_d = !((st_d == LDS_ST_READ) && (pix_d == last_pix));
  end

  // state registers; edge and rise counters start saturated so no phantom edge fires at power-up
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= LDS_ST_IDLE;
      edge_q <= LDS_EDGE_MAX;
      rise_q <= LDS_EDGE_MAX;
      phase_q <= '0;
      pix_q <= '0;
      video_q <= '0;
      drive_q <= 1'b0;
      integ_q <= 1'b0;
      gain_q <= 1'b0;
      pitch_q <= 1'b0;
      under_q <= 1'b0;
      rstp_q <= 1'b1;
      trig_q <= 1'b0;
      last_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      edge_q <= edge_d;
      rise_q <= rise_d;
      phase_q <= phase_d;
      pix_q <= pix_d;
      video_q <= video_d;
      drive_q <= drive_d;
      integ_q <= integ_d;
      gain_q <= gain_d;
      pitch_q <= pitch_d;
      under_q <= under_d;
      rstp_q <= rstp_d;
      trig_q <= trig_d;
      last_n_q <= last_n_d;
    end
  end

  // outputs straight from flops
  always_comb begin
    o_video = video_q;
    o_video_oe_n = !drive_q; // low while this unit owns the shared video line
    o_trig = trig_q;
    o_end_of_scan_out_n = last_n_q;
    o_integrating = integ_q;
    o_high_gain = gain_q;
    o_underrun = under_q;
  end

endmodule : lds_readout

// *** sim/lds_ctl_model.sv ***
// controller model: scan clock, line reset, video sampled under the trigger
// assumes i_clk at 100 MHz; the scan clock runs free at i_clk / 20
`timescale 1ns/10ps
module lds_ctl_model import lds_pkg::*; (
  input wire logic i_clk,
  input wire logic i_trig,
  input wire logic [LDS_PIX_W-1:0] i_video,
  input wire logic i_last_n,
  output logic o_scan_clk,
  output logic o_scan_rst_n,
  output logic o_got,
  output logic [LDS_PIX_W-1:0] o_word,
  output logic o_last_n
);
  logic [3:0] ph_q = 4'h0;
  logic trig_q = 1'b0;
  initial begin
    o_scan_clk = 1'b0;
    o_scan_rst_n = 1'b1;
    o_got = 1'b0;
  end
  // 100 ns phases; sample on the first falling pin edge that sees the trigger
  always @(posedge i_clk) begin
    ph_q <= (ph_q == 4'h9) ? 4'h0 : ph_q + 4'h1;
    if (ph_q == 4'h9) o_scan_clk <= ~o_scan_clk;
    o_got <= ph_q == 4'h9 && o_scan_clk && i_trig && !trig_q;
    if (ph_q == 4'h9 && o_scan_clk) begin
      trig_q <= i_trig;
      o_word <= i_video;
      o_last_n <= i_last_n;
    end
  end
  // reset moves on rising edges, half a clock clear of the sampling edges
  task run_line(input int npix);
    @(posedge i_clk iff (ph_q == 4'h9 && !o_scan_clk));
    o_scan_rst_n <= 1'b0;
    repeat (16) @(posedge i_clk iff (ph_q == 4'h9 && !o_scan_clk));
    o_scan_rst_n <= 1'b1;
    repeat (4 * npix + 40) @(posedge i_clk iff (ph_q == 4'h9 && !o_scan_clk));
  endtask : run_line
endmodule : lds_ctl_model

// *** sim/lds_readout_chk_sva.sv ***
// checker: readout timing seen at the sequencer pins
// assumes a scan clock of whole i_clk periods and reset moved off its falling edges
`timescale 1ns/10ps
module lds_readout_chk import lds_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scan_clk,
  input wire logic i_scan_rst_n,
  input wire logic i_lead_follower_select,
  input wire logic o_video_oe_n,
  input wire logic o_trig,
  input wire logic o_end_of_scan_out_n,
  input wire logic o_integrating
);
  // ==========================================================================
  // edge counters
  // ==========================================================================
  logic sc_q, rs_q, rs_d, arm_q, arm_d, fall;
  logic [4:0] e_q, e_d, r_q, r_d;
  assign fall = sc_q & ~i_scan_clk;
  // falls since reset first seen low (e) and high (r); saturate so stale lines stay quiet
  always_comb begin
    e_d = (!i_scan_rst_n && rs_q) ? 5'h00 : ((e_q == LDS_EDGE_MAX) ? e_q : e_q + 5'h01);
    r_d = (i_scan_rst_n && !rs_q) ? 5'h00 : ((r_q == LDS_EDGE_MAX) ? r_q : r_q + 5'h01);
    rs_d = fall ? i_scan_rst_n : rs_q;
    arm_d = arm_q | (fall && r_d == 5'h08);
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sc_q <= 1'b1;
      rs_q <= 1'b1;
      e_q <= LDS_EDGE_MAX;
      r_q <= LDS_EDGE_MAX;
      arm_q <= 1'b0;
    end else begin
      sc_q <= i_scan_clk;
      rs_q <= rs_d;
      e_q <= fall ? e_d : e_q;
      r_q <= fall ? r_d : r_q;
      arm_q <= arm_d;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================================
  // properties
  // ==========================================================================
  property p_first_pix;
    fall && i_lead_follower_select && e_d == 5'h12 |-> o_video_oe_n ##[1:6] !o_video_oe_n;
  endproperty
  a_first_pix: assert property (p_first_pix) else $error("first pixel late or early");
  property p_trig_on;
    fall && i_lead_follower_select && e_d == 5'h13 |-> !o_trig ##[1:6] o_trig;
  endproperty
  a_trig_on: assert property (p_trig_on) else $error("trigger not raised after edge 19");
  property p_trig_off;
    fall && i_lead_follower_select && e_d == 5'h15 |-> o_trig ##[1:6] !o_trig;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger not held over edge 20");
  property p_cadence;
    $rose(o_trig) && o_end_of_scan_out_n |-> ##80 $rose(o_trig);
  endproperty
  a_cadence: assert property (p_cadence) else $error("pixel spacing not four scan clocks");
  property p_last_slot;
    $fell(o_end_of_scan_out_n) |-> !o_video_oe_n ##20 $rose(o_trig);
  endproperty
  a_last_slot: assert property (p_last_slot) else $error("end of scan outside last slot");
  property p_last_end;
    $rose(o_end_of_scan_out_n) |-> $rose(o_video_oe_n);
  endproperty
  a_last_end: assert property (p_last_end) else $error("end of scan and video end apart");
  property p_int_end;
    fall && arm_q && e_d == 5'h07 |-> o_integrating ##[1:6] !o_integrating;
  endproperty
  a_int_end: assert property (p_int_end) else $error("integration not ended at edge 7");
  property p_int_start;
    fall && r_d == 5'h08 |-> !o_integrating ##[1:6] o_integrating;
  endproperty
  a_int_start: assert property (p_int_start) else $error("integration not begun at edge 8");
  c_first: cover property (fall && e_d == 5'h12);
  c_last: cover property ($fell(o_end_of_scan_out_n));
  c_int: cover property ($rose(o_integrating));
endmodule : lds_readout_chk

bind lds_readout lds_readout_chk u_chk (.i_clk, .i_rst, .i_scan_clk, .i_scan_rst_n,
  .i_lead_follower_select, .o_video_oe_n, .o_trig, .o_end_of_scan_out_n, .o_integrating);

// *** sim/testbench.sv ***
// bench: lds_readout against a queue model of the pixel stream, four lines
// assumes the controller model drives the scan pins and samples video
`timescale 1ns/10ps
module testbench import lds_pkg::*;;
  logic i_clk, i_rst, i_scan_clk, i_scan_rst_n, i_chain_start_in_n, i_lead_follower_select;
  logic i_gain_select, i_pitch_select, i_pix_valid, o_pix_ready, o_video_oe_n, o_trig;
  logic o_end_of_scan_out_n, o_integrating, o_high_gain, o_underrun, got, w_last_n, exp_under;
  logic [LDS_PIX_W-1:0] i_pix_data, o_video, word;
  logic [LDS_PIX_W-1:0] q[$];
  logic [31:0] seed;
  int n_mismatch, n_compared, k, n_pix, feed_left;
  lds_readout dut (.i_clk, .i_rst, .i_scan_clk, .i_scan_rst_n, .i_chain_start_in_n,
    .i_lead_follower_select, .i_gain_select, .i_pitch_select, .i_pix_valid, .i_pix_data,
    .o_pix_ready, .o_video, .o_video_oe_n, .o_trig, .o_end_of_scan_out_n, .o_integrating,
    .o_high_gain, .o_underrun);
  lds_ctl_model ctl (.i_clk(i_clk), .i_trig(o_trig), .i_video(o_video),
    .i_last_n(o_end_of_scan_out_n), .o_scan_clk(i_scan_clk), .o_scan_rst_n(i_scan_rst_n),
    .o_got(got), .o_word(word), .o_last_n(w_last_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task report_and_stop;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  always #5 i_clk = ~i_clk;
  // random pixel source; a word offered stays until the FIFO takes it
  always @(posedge i_clk) begin
    if (i_pix_valid && o_pix_ready) begin
      q.push_back(i_pix_data);
      feed_left--;
    end
    if (!i_pix_valid || o_pix_ready) begin
      seed = xs(seed);
      i_pix_valid <= (feed_left > 0) && seed[0];
      i_pix_data <= seed[12:1];
    end
  end
  // each sampled pixel against the model; an empty model queue means an underrun slot
  always @(posedge i_clk) begin
    if (got) begin
      if (q.size() == 0) exp_under = 1'b1;
      check("video", word, (q.size() > 0) ? q.pop_front() : 0);
      check("end of scan", w_last_n, (k == n_pix - 1) ? 0 : 1);
      k++;
    end
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {i_clk, i_rst, i_chain_start_in_n, i_lead_follower_select} = 4'hF;
    {i_gain_select, i_pitch_select, i_pix_valid, i_pix_data} = '0;
    seed = 32'h0000A0CF; // xorshift start, 41167
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    feed_left = 40;
    for (int i = 0; i < 400 && o_pix_ready !== 1'b0; i++) @(negedge i_clk);
    check("fifo fill", q.size(), LDS_FIFO_DEPTH);
    // lines: lead coarse, lead fine starved, follower coarse, lead fine
    for (int ln = 0; ln < 4; ln++) begin
      @(posedge i_clk);
      i_lead_follower_select <= (ln != 2);
      i_pitch_select <= ln[0];
      // xor of the two line bits, so both gain settings are seen across the four lines
      i_gain_select <= ln[0] ^ ln[1];
      @(negedge i_clk);
      feed_left = (ln == 1) ? 50 : 300;
      n_pix = ln[0] ? LDS_PIX_FINE : LDS_PIX_COARSE;
      k = 0;
      exp_under = 1'b0;
      fork
        ctl.run_line(n_pix);
        begin
          // after the reset rise, so follower video never overlaps that edge
          repeat (400) @(posedge i_clk);
          i_chain_start_in_n <= 1'b0;
        end
      join
      @(posedge i_clk);
      i_chain_start_in_n <= 1'b1;
      @(negedge i_clk);
      check("pixel count", k, n_pix);
      check("underrun", o_underrun, exp_under);
      check("gain", o_high_gain, i_gain_select);
      check("integrating", o_integrating, 1);
    end
    report_and_stop();
  end
endmodule : testbench
